// [supply_condition_status.sv]
// Notes on behaviour
// - bit 4 shows regulator over-voltage warning live
// - status read clears over-voltage flag
// - bit 3 shows regulator hot warning live
// - status read clears hot flag
// - bit 2 shows supply two high warning
// - status read clears high-voltage flag
// - bit 1 shows supply one low warning
// - status read clears low-voltage flag
// - bit 0 shows battery low warning
// - status read clears low-battery flag
// - flags rise only when enable bit set
// - all five flags ORed into summary interrupt
// - decode offsets from 0x0200 or 0x300 base
`timescale 1ns/1ps
module supply_condition_status (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // warning comparators
    input  wire logic                          regulatorOvervoltageCond,
    input  wire logic                          regulatorHotCond,
    input  wire logic                          supplyTwoHighCond,
    input  wire logic                          supplyOneLowCond,
    input  wire logic                          batteryLowCond,
    // register access from the die-to-die target
    input  wire logic                          regRead,
    input  wire logic                          regWrite,
    input  wire logic                          nonBlocking,
    input  wire logic [15:0]                   hostAddr,
    input  wire logic [7:0]                    regWdata,
    output logic      [7:0]                    regRdata,
    output logic                               regAck,
    // interrupt flags and summary
    output logic [supply_status_pkg::WARN_COUNT-1:0] irqFlags,
    output logic                               voltageSummaryIrq
);
    import supply_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // true when the address falls in the selected window
    function automatic logic inWindow(input logic [15:0] a,
                                      input logic nb);
        logic [15:0] base;
        base = nb ? NONBLOCKING_BASE : BLOCKING_BASE;
        return (a >= base) && (a < (base + WINDOW_SPAN));
    endfunction

    // offset of the address within the selected window
    function automatic logic [7:0] winOffset(input logic [15:0] a,
                                             input logic nb);
        logic [15:0] diff;
        diff = a - (nb ? NONBLOCKING_BASE : BLOCKING_BASE);
        return diff[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [4:0] condVec;         // live warnings, status bit order
    logic       hitEnable;       // access targets enable register
    logic       hitStatus;       // access targets status register
    logic       statusRead;      // read of status, clears flags
    logic [4:0] enable_q;        // supply_irq_enable_reg
    logic [4:0] enable_d;
    logic [7:0] rdata_q;         // registered read data
    logic [7:0] rdata_d;
    logic       ack_q;           // one-cycle answer
    logic       ack_d;
    logic [4:0] flags;           // latched flags from the bank

    ////////////////////////////////////////////////////////////////////////
    // live condition vector

    always_comb begin
        condVec                   = '0;
        condVec[BIT_REG_OVERVOLT] = regulatorOvervoltageCond;
        condVec[BIT_REG_HOT]      = regulatorHotCond;
        condVec[BIT_TWO_HIGH]     = supplyTwoHighCond;
        condVec[BIT_ONE_LOW]      = supplyOneLowCond;
        condVec[BIT_BATT_LOW]     = batteryLowCond;
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode

    always_comb begin
        hitEnable  = inWindow(hostAddr, nonBlocking) &&
                     (winOffset(hostAddr, nonBlocking) == ENABLE_OFFSET);
        hitStatus  = inWindow(hostAddr, nonBlocking) &&
                     (winOffset(hostAddr, nonBlocking) == STATUS_OFFSET);
        // only a read of status clears the flags
        statusRead = regRead && hitStatus;
    end

    ////////////////////////////////////////////////////////////////////////
    // register file next state

    always_comb begin
        enable_d = enable_q;
        rdata_d  = rdata_q;
        ack_d    = regRead || regWrite;
        // enable register takes writes; status ignores them
        if (regWrite && hitEnable) begin
            enable_d = regWdata[4:0];
        end
        // read data, unmapped offsets read zero
        if (regRead) begin
            if (hitStatus) begin
                rdata_d = {3'h0, condVec};
            end else if (hitEnable) begin
                rdata_d = {3'h0, enable_q};
            end else begin
                rdata_d = RDATA_RESET;
            end
        end
    end

    // register file registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enable_q <= ENABLE_RESET;
            rdata_q  <= RDATA_RESET;
            ack_q    <= 1'b0;
        end else begin
            enable_q <= enable_d;
            rdata_q  <= rdata_d;
            ack_q    <= ack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched flags, cleared by a status read

    supply_flag_bank flagBank (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .condIn   (condVec),
        .enableIn (enable_q),
        .clearAll (statusRead),
        .flagOut  (flags)
    );

    // outputs
    assign regRdata          = rdata_q;
    assign regAck            = ack_q;
    assign irqFlags          = flags;
    assign voltageSummaryIrq = |flags;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_readOv;
        statusRead |=> regRdata[BIT_REG_OVERVOLT] ==
                       $past(regulatorOvervoltageCond);
    endproperty
    a_readOv: assert property (p_readOv)
        else $error("status bit 4 mismatch");

    property p_readHot;
        statusRead |=> regRdata[BIT_REG_HOT] == $past(regulatorHotCond);
    endproperty
    a_readHot: assert property (p_readHot)
        else $error("status bit 3 mismatch");

    property p_readTwoHigh;
        statusRead |=> regRdata[BIT_TWO_HIGH] == $past(supplyTwoHighCond);
    endproperty
    a_readTwoHigh: assert property (p_readTwoHigh)
        else $error("status bit 2 mismatch");

    property p_readOneLow;
        statusRead |=> regRdata[BIT_ONE_LOW] == $past(supplyOneLowCond);
    endproperty
    a_readOneLow: assert property (p_readOneLow)
        else $error("status bit 1 mismatch");

    property p_readBatt;
        statusRead |=> regRdata[BIT_BATT_LOW] == $past(batteryLowCond);
    endproperty
    a_readBatt: assert property (p_readBatt)
        else $error("status bit 0 mismatch");

    property p_clearOv;
        statusRead && !($rose(regulatorOvervoltageCond) &&
                        enable_q[BIT_REG_OVERVOLT])
        |=> !flags[BIT_REG_OVERVOLT];
    endproperty
    a_clearOv: assert property (p_clearOv)
        else $error("over-voltage flag not cleared by read");

    property p_clearBatt;
        statusRead && !($rose(batteryLowCond) && enable_q[BIT_BATT_LOW])
        |=> !flags[BIT_BATT_LOW];
    endproperty
    a_clearBatt: assert property (p_clearBatt)
        else $error("low-battery flag not cleared by read");

    property p_enableGate;
        !enable_q[BIT_REG_HOT] && !flags[BIT_REG_HOT]
        |=> !flags[BIT_REG_HOT];
    endproperty
    a_enableGate: assert property (p_enableGate)
        else $error("hot flag rose while disabled");

    property p_summary;
        $rose(regulatorHotCond) && enable_q[BIT_REG_HOT]
        |=> voltageSummaryIrq;
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary interrupt mismatch");

    property p_nbBase;
        regRead && nonBlocking && hostAddr ==
            (NONBLOCKING_BASE + {8'h00, STATUS_OFFSET})
        |=> regRdata[4:0] == $past(condVec);
    endproperty
    a_nbBase: assert property (p_nbBase)
        else $error("non-blocking status decode failed");

    property p_upperZero;
        statusRead |=> regAck && regRdata[7:5] == 3'h0;
    endproperty
    a_upperZero: assert property (p_upperZero)
        else $error("status upper bits not zero");

    property p_writeIgnored;
        regWrite && hitStatus && !regRead |=> $stable(enable_q);
    endproperty
    a_writeIgnored: assert property (p_writeIgnored)
        else $error("status write had effect");

    c_readWithFlag: cover property (statusRead && flags != 5'h00);
    c_setAndClear: cover property (statusRead ##1 voltageSummaryIrq);
    c_nbAccess: cover property (statusRead && nonBlocking);

endmodule

// [supply_condition_status_tb.sv]
`timescale 1ns/1ps
module supply_condition_status_tb;
    import supply_status_pkg::*;
    // clock, reset and live conditions
    logic        clk = 1'b0;
    logic        sysRst = 1'b1;
    logic [4:0]  cond = 5'h00;
    // bus between host model and block
    wire         rdReq, wrReq, nb, ack, summary;
    wire  [15:0] addr;
    wire  [7:0]  wdata, rdata;
    wire  [4:0]  flags;
    int          mismatches = 0;
    int          samplesChecked = 0;
    // register addresses widened to the host task's offset width
    localparam logic [15:0] STATUS_OFS = {8'h00, STATUS_OFFSET};
    localparam logic [15:0] ENABLE_OFS = {8'h00, ENABLE_OFFSET};
    //////////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;
    supply_condition_status u_dut (.clk(clk), .sys_rst(sysRst),
        .regulatorOvervoltageCond(cond[4]), .regulatorHotCond(cond[3]),
        .supplyTwoHighCond(cond[2]), .supplyOneLowCond(cond[1]),
        .batteryLowCond(cond[0]), .regRead(rdReq), .regWrite(wrReq),
        .nonBlocking(nb), .hostAddr(addr), .regWdata(wdata),
        .regRdata(rdata), .regAck(ack), .irqFlags(flags),
        .voltageSummaryIrq(summary));
    supply_host_model u_host (.clk(clk), .regRead(rdReq), .regWrite(wrReq),
        .nonBlocking(nb), .hostAddr(addr), .regWdata(wdata),
        .regRdata(rdata), .regAck(ack));
    //////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // bus access with ack check, missing ack ends the run
    task automatic acc(input logic w, input logic n, input logic [15:0] o,
                       input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] r;
        logic       a;
        u_host.access(w, n, o, d, r, a);
        check({7'h00, a}, 8'h01);
        if (!a) begin
            wrap_up();
        end
        if (!w) begin
            check(r, exp);
        end
    endtask
    task automatic setCond(input logic [4:0] v);
        @(posedge clk);
        #1;
        cond = v;
    endtask
    // one source live while its interrupt stays disabled
    task automatic liveBit(input logic [4:0] v, input logic n);
        setCond(v);
        acc(0, n, STATUS_OFS, 8'h00, 8'(v));
        check(8'(flags), 8'h00);
    endtask
    // one enabled source raised, flagged, read and cleared
    task automatic flagBit(input logic [4:0] v, input logic n);
        setCond(v);
        setCond(v);
        check(8'(flags), 8'(v));
        check({7'h00, summary}, 8'h01);
        acc(0, n, STATUS_OFS, 8'h00, 8'(v));
        check(8'(flags), 8'h00);
        setCond(5'h00);
    endtask
    //////////////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        sysRst = 1'b0;
        check(8'(flags), 8'h00);
        acc(0, 0, STATUS_OFS, 8'h00, 8'h00);
        // each bit live while sources are disabled
        liveBit(5'h01, 1'b0);
        liveBit(5'h02, 1'b1);
        liveBit(5'h04, 1'b0);
        liveBit(5'h08, 1'b1);
        liveBit(5'h10, 1'b0);
        // status ignores writes, enable keeps its value
        acc(1, 0, STATUS_OFS, 8'hff, 8'h00);
        acc(0, 1, STATUS_OFS, 8'h00, 8'h10);
        acc(0, 0, ENABLE_OFS, 8'h00, 8'h00);
        setCond(5'h00);
        // only the enabled source latches, level sets once
        acc(1, 1, ENABLE_OFS, 8'h04, 8'h00);
        acc(0, 0, ENABLE_OFS, 8'h00, 8'h04);
        setCond(5'h1f);
        setCond(5'h1f);
        check(8'(flags), 8'h04);
        acc(0, 0, STATUS_OFS, 8'h00, 8'h1f);
        repeat (3) setCond(5'h1f);
        check(8'(flags), 8'h00);
        check({7'h00, summary}, 8'h00);
        // every source enabled, raised, read and cleared
        acc(1, 0, ENABLE_OFS, 8'h1f, 8'h00);
        setCond(5'h00);
        flagBit(5'h01, 1'b0);
        flagBit(5'h02, 1'b1);
        flagBit(5'h04, 1'b0);
        flagBit(5'h08, 1'b1);
        flagBit(5'h10, 1'b0);
        // decode: unmapped, out of window, raw window address
        setCond(5'h1f);
        acc(0, 0, 16'h0050, 8'h00, 8'h00);
        acc(0, 0, 16'h0212, 8'h00, 8'h00);
        acc(0, 1, 16'h0012, 8'h00, 8'h1f);
        // mid-run reset drops flags and enables
        setCond(5'h00);
        setCond(5'h1f);
        setCond(5'h1f);
        check(8'(flags), 8'h1f);
        @(posedge clk);
        #1;
        sysRst = 1'b1;
        @(posedge clk);
        #1;
        sysRst = 1'b0;
        check(8'(flags), 8'h00);
        check({7'h00, summary}, 8'h00);
        acc(0, 0, ENABLE_OFS, 8'h00, 8'h00);
        acc(0, 0, STATUS_OFS, 8'h00, 8'h1f);
        check(8'(flags), 8'h00);
        wrap_up();
    end
endmodule

// [supply_flag_bank.sv]
`timescale 1ns/1ps
module supply_flag_bank (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // live conditions and their enables
    input  wire logic [4:0] condIn,
    input  wire logic [4:0] enableIn,
    // one-cycle clear from a status read
    input  wire logic       clearAll,
    // latched interrupt flags
    output logic      [4:0] flagOut
);
    import supply_status_pkg::*;

    logic [4:0] flag_q;     // sticky flags
    logic [4:0] flag_d;
    logic [4:0] condPrev_q; // last cycle's conditions
    logic [4:0] condPrev_d;
    logic [4:0] setEvt;     // enabled rising edges

    ////////////////////////////////////////////////////////////////////////
    // next flag values: a new event beats a clear in the same cycle
    always_comb begin
        condPrev_d = condIn;
        setEvt     = condIn & ~condPrev_q & enableIn;
        flag_d     = setEvt | (flag_q & ~{5{clearAll}});
    end

    // registers only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_q     <= FLAG_RESET;
            condPrev_q <= FLAG_RESET;
        end else begin
            flag_q     <= flag_d;
            condPrev_q <= condPrev_d;
        end
    end

    assign flagOut = flag_q;

endmodule

// [supply_host_model.sv]
`timescale 1ns/1ps
module supply_host_model (
    // clock
    input  wire logic        clk,
    // request side
    output logic             regRead,
    output logic             regWrite,
    output logic             nonBlocking,
    output logic [15:0]      hostAddr,
    output logic [7:0]       regWdata,
    // answer side
    input  wire logic [7:0]  regRdata,
    input  wire logic        regAck
);
    import supply_status_pkg::*;
    //////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        regRead = 1'b0;
        regWrite = 1'b0;
        nonBlocking = 1'b0;
        hostAddr = 16'h0000;
        regWdata = 8'h00;
    end
    //////////////////////////////////////////////////////////////////////
    // one access: one-cycle request pulse, then a bounded wait for the ack
    task automatic access(input logic wr, input logic nb,
                          input logic [15:0] offset, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic acked);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        regRead = !wr;
        regWrite = wr;
        nonBlocking = nb;
        // window base picked by access kind
        hostAddr = (nb ? NONBLOCKING_BASE : BLOCKING_BASE) + offset;
        regWdata = wdata;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        regWrite = 1'b0;
        // released lines do not keep their last value
        hostAddr = ~hostAddr;
        regWdata = ~regWdata;
        while (regAck !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        rdata = regRdata;
        acked = (regAck === 1'b1);
    endtask
endmodule

// [supply_status_pkg.sv]
package supply_status_pkg;

    // number of warning sources
    localparam int unsigned WARN_COUNT = 5;

    // host address windows for blocking and non-blocking accesses
    localparam logic [15:0] BLOCKING_BASE    = 16'h0200;
    localparam logic [15:0] NONBLOCKING_BASE = 16'h0300;
    localparam logic [15:0] WINDOW_SPAN      = 16'h0100;

    // register offsets inside the window
    localparam logic [7:0] ENABLE_OFFSET = 8'h10;
    localparam logic [7:0] STATUS_OFFSET = 8'h12;

    // bit positions, shared by status, enable and flag vectors
    localparam int unsigned BIT_REG_OVERVOLT = 4;
    localparam int unsigned BIT_REG_HOT      = 3;
    localparam int unsigned BIT_TWO_HIGH     = 2;
    localparam int unsigned BIT_ONE_LOW      = 1;
    localparam int unsigned BIT_BATT_LOW     = 0;

    // values after reset
    localparam logic [4:0] ENABLE_RESET = 5'h00;
    localparam logic [4:0] FLAG_RESET   = 5'h00;
    localparam logic [7:0] RDATA_RESET  = 8'h00;

endpackage
